// >>> rtl/crm_misc_regs.sv
`timescale 1ns/10ps
// Overview of operation
// - Rail enable follows host control bit
// - Thermal trip forces rail enable off
// - Rail drop while enabled raises fault irq
// - Own ID at 0x00, read-only
// - Companion ID at 0x01, read-only
// - 0x02 and 0x03 read zero
// - Twenty-four backup scratch bytes
// - Scratch cleared only by backup reset
// - Eight main, sixteen vendor scratch bytes
// - Drive code 10 means Hi-Z
// - Drive control one at 0x1BF
// - Drive control two at 0x1C0
// - Drive control three at 0x1C1
// - Synth control at 0x1E4, reset 0x1B
// - Divider code selects 112..140 step four
// - Bit 3 enables synth and 16M out
// - Bit 4 forces synth run
module crm_misc_regs
  import crm_pkg::*;
#(
  parameter logic [2:0] OWN_MAKER  = 3'h1, // Arbitrary value
  parameter logic [2:0] OWN_REV    = 3'h2, // Arbitrary value
  parameter logic [2:0] COMP_MAKER = 3'h3, // Arbitrary value
  parameter logic [2:0] COMP_REV   = 3'h4  // Arbitrary value
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       backup_domain_por_n,
  input  wire crm_req_s   req,
  output logic      [7:0] rdata,
  input  wire logic       thermal_trip_n,
  input  wire logic       companion_rail_status_n,
  input  wire logic       synth_block_request,
  output logic            companion_rail_enable_out,
  output logic            regulator_fault_irq,
  output logic            synth_run,
  output logic            synth_16m_output_enable,
  output logic      [7:0] synth_divide_ratio,
  output crm_drive_s      drive,
  output logic            companion_rail_enable_hiz
);

  logic [7:0] drive_one_reg;
  logic [7:0] drive_two_reg;
  logic [7:0] drive_three_reg;
  logic [7:0] synth_ctrl_reg;
  logic [7:0] rail_ctrl_reg;
  logic       trip_meta_reg;
  logic       trip_sync_reg;
  logic       stat_meta_reg;
  logic       stat_sync_reg;
  logic       fault_reg;
  logic       rail_en_reg;
  logic       scr_wr;
  logic [4:0] scr_idx;
  logic       scr_hit;
  logic [7:0] scr_rdata;
  logic [7:0] rdata_next;
  logic       fault_event;

  function automatic logic [7:0] div_ratio(input logic [2:0] code);
    div_ratio = SYN_DIV_BASE + (8'(code) << SYN_DIV_STEP_SHIFT);
  endfunction

  // Pins from outside pass two flops first
  always_ff @(posedge clk) begin
    if (!rstn) begin
      trip_meta_reg <= 1'b1;
      trip_sync_reg <= 1'b1;
      stat_meta_reg <= 1'b1;
      stat_sync_reg <= 1'b1;
    end else begin
      trip_meta_reg <= thermal_trip_n;
      trip_sync_reg <= trip_meta_reg;
      stat_meta_reg <= companion_rail_status_n;
      stat_sync_reg <= stat_meta_reg;
    end
  end

  // Scratch decode: main bytes then vendor bytes
  always_comb begin
    scr_hit = 1'b0;
    scr_idx = 5'h00;
    if (req.addr >= OFS_SCRATCH_MAIN &&
        req.addr < OFS_SCRATCH_MAIN + 9'(SCRATCH_MAIN_N)) begin
      scr_hit = 1'b1;
      scr_idx = 5'(req.addr - OFS_SCRATCH_MAIN);
    end else if (req.addr >= OFS_SCRATCH_VEND &&
        req.addr < OFS_SCRATCH_VEND + 9'(SCRATCH_VEND_N)) begin
      scr_hit = 1'b1;
      scr_idx = 5'(req.addr - OFS_SCRATCH_VEND) + 5'(SCRATCH_MAIN_N);
    end
  end

  assign scr_wr = req.wr && scr_hit;

  crm_scratch #(.DEPTH(SCRATCH_N)) u_scratch (
    .clk                 (clk),
    .backup_domain_por_n (backup_domain_por_n),
    .wr_en               (scr_wr),
    .idx                 (scr_idx),
    .wdata               (req.wdata),
    .rdata               (scr_rdata)
  );

  // Host-writable control; reserved bits are masked off
  always_ff @(posedge clk) begin
    if (!rstn) begin
      drive_one_reg   <= RST_DRIVE_ONE;
      drive_two_reg   <= RST_DRIVE_TWO;
      drive_three_reg <= RST_DRIVE_THREE;
      synth_ctrl_reg  <= RST_SYNTH_CTRL;
      rail_ctrl_reg   <= RST_RAIL_CTRL;
    end else if (req.wr) begin
      case (req.addr)
        OFS_DRIVE_ONE:   drive_one_reg   <= req.wdata;
        OFS_DRIVE_TWO:   drive_two_reg   <= req.wdata;
        OFS_DRIVE_THREE: drive_three_reg <= req.wdata & MASK_DRIVE_THREE;
        OFS_SYNTH_CTRL:  synth_ctrl_reg  <= req.wdata & MASK_SYNTH_CTRL;
        OFS_RAIL_CTRL:   rail_ctrl_reg   <= req.wdata & MASK_RAIL_CTRL;
        default: begin
        end
      endcase
    end
  end

  // Trip overrides host setting without host action
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rail_en_reg <= 1'b0;
    end else begin
      rail_en_reg <= rail_ctrl_reg[0] && trip_sync_reg;
    end
  end

  // Rail reported off while we drive it on: local shutdown.
  // Status comes back through the companion and two sync flops,
  // so it is ignored until enable has stood for two edges.
  logic rail_en_d_reg;
  logic rail_en_d2_reg;
  logic fault_clear;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rail_en_d_reg  <= 1'b0;
      rail_en_d2_reg <= 1'b0;
    end else begin
      rail_en_d_reg  <= rail_en_reg;
      rail_en_d2_reg <= rail_en_d_reg;
    end
  end

  assign fault_event = rail_en_reg && rail_en_d_reg && rail_en_d2_reg &&
                       stat_sync_reg;
  assign fault_clear = req.wr && (req.addr == OFS_RAIL_STATUS) &&
                       req.wdata[0];

  // Sticky fault; a clear in the same cycle loses to a new event
  always_ff @(posedge clk) begin
    if (!rstn) begin
      fault_reg <= 1'b0;
    end else if (fault_event) begin
      fault_reg <= 1'b1;
    end else if (fault_clear) begin
      fault_reg <= 1'b0;
    end
  end

  always_comb begin
    rdata_next = 8'h00;
    if (scr_hit) begin
      rdata_next = scr_rdata;
    end else begin
      case (req.addr)
        OFS_ID_PRIMARY:   rdata_next = {2'b00, OWN_REV, OWN_MAKER};
        OFS_ID_COMPANION: rdata_next = {2'b00, COMP_REV, COMP_MAKER};
        OFS_ID_SPARE_A:   rdata_next = 8'h00;
        OFS_ID_SPARE_B:   rdata_next = 8'h00;
        OFS_RAIL_CTRL:    rdata_next = rail_ctrl_reg;
        OFS_RAIL_STATUS:  rdata_next = {5'h00, ~stat_sync_reg,
                                        rail_en_reg, fault_reg};
        OFS_DRIVE_ONE:    rdata_next = drive_one_reg;
        OFS_DRIVE_TWO:    rdata_next = drive_two_reg;
        OFS_DRIVE_THREE:  rdata_next = drive_three_reg;
        OFS_SYNTH_CTRL:   rdata_next = synth_ctrl_reg;
        default:          rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      rdata <= rdata_next;
    end
  end

  // Synthesizer controls
  always_ff @(posedge clk) begin
    if (!rstn) begin
      synth_run               <= 1'b0;
      synth_16m_output_enable <= 1'b0;
      synth_divide_ratio      <= 8'h00;
    end else begin
      synth_16m_output_enable <= synth_ctrl_reg[SYN_OUT16_BIT];
      synth_run <= synth_ctrl_reg[SYN_FORCE_BIT] ||
                   synth_ctrl_reg[SYN_OUT16_BIT] ||
                   synth_block_request;
      synth_divide_ratio <= div_ratio(synth_ctrl_reg[2:0]);
    end
  end

  assign companion_rail_enable_out = rail_en_reg;
  assign regulator_fault_irq       = fault_reg;

  always_comb begin
    drive.power_good_drive_sel       = drive_one_reg[1:0];
    drive.regulator_comp_drive_sel   = drive_one_reg[3:2];
    drive.irq_out_drive_sel          = drive_one_reg[5:4];
    drive.reset_out_drive_sel        = drive_one_reg[7:6];
    drive.slow_clock_drive_sel       = drive_two_reg[1:0];
    drive.audio_clock_drive_sel      = drive_two_reg[3:2];
    drive.secondary_enable_drive_sel = drive_two_reg[5:4];
    drive.companion_enable_drive_sel = drive_two_reg[7:6];
    drive.serial_out_drive_sel       = drive_three_reg[1:0];
  end

  // Code 10 floats the pin instead of driving it
  assign companion_rail_enable_hiz = (drive_two_reg[7:6] == DRV_HIZ);

  property p_trip_off;
    @(posedge clk) disable iff (!rstn)
      !trip_sync_reg |=> !companion_rail_enable_out;
  endproperty
  a_trip_off: assert property (p_trip_off)
    else $error("rail on in trip");

  property p_rail_follow;
    @(posedge clk) disable iff (!rstn)
      rail_ctrl_reg[0] && trip_sync_reg |=> companion_rail_enable_out;
  endproperty
  a_rail_follow: assert property (p_rail_follow)
    else $error("rail not on");

  sequence s_rail_lost;
    rail_en_reg && rail_en_d_reg && rail_en_d2_reg && stat_sync_reg;
  endsequence
  property p_fault;
    @(posedge clk) disable iff (!rstn)
      s_rail_lost |=> regulator_fault_irq;
  endproperty
  a_fault: assert property (p_fault)
    else $error("fault missed");

  property p_fault_cause;
    @(posedge clk) disable iff (!rstn)
      $rose(regulator_fault_irq) |-> $past(fault_event);
  endproperty
  a_fault_cause: assert property (p_fault_cause)
    else $error("fault uncaused");

  property p_div;
    @(posedge clk) disable iff (!rstn)
      1'b1 |=> synth_divide_ratio ==
               8'h70 + 8'h04 * 8'($past(synth_ctrl_reg[2:0]));
  endproperty
  a_div: assert property (p_div)
    else $error("bad divide ratio");

  property p_out16;
    @(posedge clk) disable iff (!rstn)
      synth_ctrl_reg[3] |=> synth_16m_output_enable && synth_run;
  endproperty
  a_out16: assert property (p_out16)
    else $error("16M not enabled");

  property p_idle;
    @(posedge clk) disable iff (!rstn)
      !synth_ctrl_reg[4] && !synth_ctrl_reg[3] && !synth_block_request
      |=> !synth_run;
  endproperty
  a_idle: assert property (p_idle)
    else $error("synth runs idle");

  property p_rsvd;
    @(posedge clk) disable iff (!rstn)
      synth_ctrl_reg[7:5] == 3'h0 && drive_three_reg[7:2] == 6'h00;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bit set");

  property p_id_zero;
    @(posedge clk) disable iff (!rstn)
      req.rd && (req.addr == OFS_ID_SPARE_A || req.addr == OFS_ID_SPARE_B)
      |=> rdata == 8'h00;
  endproperty
  a_id_zero: assert property (p_id_zero)
    else $error("spare id nonzero");

  property p_id_own;
    @(posedge clk) disable iff (!rstn)
      req.rd && req.addr == OFS_ID_PRIMARY
      |=> rdata == {2'h0, OWN_REV, OWN_MAKER};
  endproperty
  a_id_own: assert property (p_id_own)
    else $error("own id wrong");

  property p_fault_clear;
    @(posedge clk) disable iff (!rstn)
      fault_clear && !fault_event |=> !regulator_fault_irq;
  endproperty
  a_fault_clear: assert property (p_fault_clear)
    else $error("fault not cleared");

  property p_fault_sticky;
    @(posedge clk) disable iff (!rstn)
      regulator_fault_irq && !fault_clear |=> regulator_fault_irq;
  endproperty
  a_fault_sticky: assert property (p_fault_sticky)
    else $error("fault dropped");

endmodule

// >>> rtl/crm_pkg.sv
package crm_pkg;

  localparam int unsigned ADDR_W = 9;
  localparam int unsigned DATA_W = 8;

  localparam logic [8:0] OFS_ID_PRIMARY   = 9'h000;
  localparam logic [8:0] OFS_ID_COMPANION = 9'h001;
  localparam logic [8:0] OFS_ID_SPARE_A   = 9'h002;
  localparam logic [8:0] OFS_ID_SPARE_B   = 9'h003;
  localparam logic [8:0] OFS_RAIL_CTRL    = 9'h004;
  localparam logic [8:0] OFS_RAIL_STATUS  = 9'h005;
  localparam logic [8:0] OFS_SCRATCH_MAIN = 9'h010;
  localparam logic [8:0] OFS_SCRATCH_VEND = 9'h1a0;
  localparam logic [8:0] OFS_DRIVE_ONE    = 9'h1bf;
  localparam logic [8:0] OFS_DRIVE_TWO    = 9'h1c0;
  localparam logic [8:0] OFS_DRIVE_THREE  = 9'h1c1;
  localparam logic [8:0] OFS_SYNTH_CTRL   = 9'h1e4;

  localparam int unsigned SCRATCH_MAIN_N = 8;
  localparam int unsigned SCRATCH_VEND_N = 16;
  localparam int unsigned SCRATCH_N      = 24;

  localparam logic [7:0] RST_DRIVE_ONE   = 8'h00;
  localparam logic [7:0] RST_DRIVE_TWO   = 8'h04;
  localparam logic [7:0] RST_DRIVE_THREE = 8'h01;
  localparam logic [7:0] RST_SYNTH_CTRL  = 8'h1b;
  localparam logic [7:0] RST_RAIL_CTRL   = 8'h00;
  localparam logic [7:0] RST_SCRATCH     = 8'h00;

  localparam logic [7:0] MASK_DRIVE_THREE = 8'h03;
  localparam logic [7:0] MASK_SYNTH_CTRL  = 8'h1f;
  localparam logic [7:0] MASK_RAIL_CTRL   = 8'h01;

  localparam int unsigned SYN_DIV_LSB   = 0;
  localparam int unsigned SYN_OUT16_BIT = 3;
  localparam int unsigned SYN_FORCE_BIT = 4;
  localparam logic [7:0]  SYN_DIV_BASE  = 8'h70;
  localparam int unsigned SYN_DIV_STEP_SHIFT = 2;

  localparam logic [1:0] DRV_HIZ = 2'h2;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [8:0] addr;
    logic [7:0] wdata;
  } crm_req_s;

  typedef struct packed {
    logic [1:0] power_good_drive_sel;
    logic [1:0] regulator_comp_drive_sel;
    logic [1:0] irq_out_drive_sel;
    logic [1:0] reset_out_drive_sel;
    logic [1:0] slow_clock_drive_sel;
    logic [1:0] audio_clock_drive_sel;
    logic [1:0] secondary_enable_drive_sel;
    logic [1:0] companion_enable_drive_sel;
    logic [1:0] serial_out_drive_sel;
  } crm_drive_s;

endpackage

// >>> rtl/crm_scratch.sv
`timescale 1ns/10ps
module crm_scratch
  import crm_pkg::*;
#(
  parameter int unsigned DEPTH = SCRATCH_N
) (
  input  wire logic       clk,
  input  wire logic       backup_domain_por_n,
  input  wire logic       wr_en,
  input  wire logic [4:0] idx,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata
);

  // Index is five bits wide, so more than 32 bytes cannot be reached
  if (DEPTH < 1 || DEPTH > 32) begin : g_depth_chk
    $error("crm_scratch: DEPTH out of range");
  end

  logic [7:0] mem_reg [DEPTH];

  // Only the backup-domain reset clears this store
  always_ff @(posedge clk) begin
    if (!backup_domain_por_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= RST_SCRATCH;
      end
    end else if (wr_en && (32'(idx) < DEPTH)) begin
      mem_reg[idx] <= wdata;
    end
  end

  assign rdata = (32'(idx) < DEPTH) ? mem_reg[idx] : 8'h00;

endmodule

// >>> tb/crm_companion_model.sv
`timescale 1ns/10ps
module crm_companion_model (
  input  wire logic enable_in,
  input  wire logic local_fault,
  output logic      status_n
);
  // Plain level pin; a local fault drops the rail even while enabled
  assign status_n = ~(enable_in & ~local_fault);
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import crm_pkg::*;
  localparam logic [2:0] OM = 3'h5; // Arbitrary value
  localparam logic [2:0] OR = 3'h6; // Arbitrary value
  localparam logic [2:0] CM = 3'h2; // Arbitrary value
  localparam logic [2:0] CR = 3'h7; // Arbitrary value
  logic       clk, rstn, bpor_n, trip_n, status_n, blk_req, fail;
  logic       en_out, irq, run, out16, hiz;
  logic [7:0] rdata, ratio, v;
  logic [7:0] mem [24];
  crm_req_s   req;
  crm_drive_s drive;
  int         n_errors, total_checks, seed;

  crm_misc_regs #(.OWN_MAKER(OM), .OWN_REV(OR), .COMP_MAKER(CM),
    .COMP_REV(CR)) u_dut (.clk(clk), .rstn(rstn),
    .backup_domain_por_n(bpor_n), .req(req), .rdata(rdata),
    .thermal_trip_n(trip_n), .companion_rail_status_n(status_n),
    .synth_block_request(blk_req), .companion_rail_enable_out(en_out),
    .regulator_fault_irq(irq), .synth_run(run),
    .synth_16m_output_enable(out16), .synth_divide_ratio(ratio),
    .drive(drive), .companion_rail_enable_hiz(hiz));
  crm_companion_model u_comp (.enable_in(en_out), .local_fault(fail),
    .status_n(status_n));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [8:0] scr_addr(input int k);
    return (k < 8) ? OFS_SCRATCH_MAIN + 9'(k) : OFS_SCRATCH_VEND + 9'(k - 8);
  endfunction

  task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req = '0;
  endtask

  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    req = '0;
    chk($sformatf("reg %h", a), e, rdata);
  endtask

  task automatic summarize;
    if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #200000;
    n_errors++;
    summarize();
  end

  initial begin
    seed = 32'h605c;
    rstn = 1'b0;
    bpor_n = 1'b0;
    trip_n = 1'b1;
    fail = 1'b0;
    blk_req = 1'b0;
    req = '0;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    bpor_n = 1'b1;
    rd(OFS_ID_PRIMARY, {2'b00, OR, OM});
    rd(OFS_ID_COMPANION, {2'b00, CR, CM});
    wr(OFS_ID_PRIMARY, 8'hff);
    rd(OFS_ID_PRIMARY, {2'b00, OR, OM});
    rd(OFS_ID_SPARE_A, 8'h00);
    rd(OFS_ID_SPARE_B, 8'h00);
    rd(9'h0ff, 8'h00);
    rd(OFS_DRIVE_ONE, 8'h00);
    rd(OFS_DRIVE_TWO, 8'h04);
    rd(OFS_DRIVE_THREE, 8'h01);
    rd(OFS_SYNTH_CTRL, 8'h1b);
    // Every divider code, with random force and request bits around it
    for (int i = 0; i < 8; i++) begin
      v = 8'($random(seed));
      v[2:0] = 3'(i);
      blk_req = 1'($random(seed));
      wr(OFS_SYNTH_CTRL, v);
      repeat (2) @(negedge clk);
      chk("ratio", 8'h70 + 8'(4 * i), ratio);
      chk("out16", {7'h00, v[3]}, {7'h00, out16});
      chk("run", {7'h00, v[4] | v[3] | blk_req}, {7'h00, run});
      rd(OFS_SYNTH_CTRL, v & 8'h1f);
    end
    // Each two-bit code in the top field, including the Hi-Z code
    for (int j = 0; j < 4; j++) begin
      v = 8'($random(seed));
      v[7:6] = 2'(j);
      wr(OFS_DRIVE_ONE, v);
      wr(OFS_DRIVE_TWO, ~v);
      wr(OFS_DRIVE_THREE, v);
      @(negedge clk);
      chk("drv1", v, {drive.reset_out_drive_sel, drive.irq_out_drive_sel,
        drive.regulator_comp_drive_sel, drive.power_good_drive_sel});
      chk("drv2", ~v, {drive.companion_enable_drive_sel,
        drive.secondary_enable_drive_sel, drive.audio_clock_drive_sel,
        drive.slow_clock_drive_sel});
      chk("drv3", {6'h00, v[1:0]}, {6'h00, drive.serial_out_drive_sel});
      chk("hiz", {7'h00, ~v[7:6] == 2'b10}, {7'h00, hiz});
      rd(OFS_DRIVE_THREE, v & 8'h03);
    end
    for (int k = 0; k < 24; k++) begin
      mem[k] = 8'($random(seed));
      wr(scr_addr(k), mem[k]);
    end
    // A main reset must leave the backup bytes alone
    rstn = 1'b0;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    rd(OFS_DRIVE_TWO, 8'h04);
    for (int k = 0; k < 24; k++) rd(scr_addr(k), mem[k]);
    bpor_n = 1'b0;
    @(negedge clk);
    bpor_n = 1'b1;
    for (int k = 0; k < 24; k++) rd(scr_addr(k), 8'h00);
    wr(OFS_RAIL_CTRL, 8'h01);
    repeat (6) @(negedge clk);
    chk("rail_en", 8'h01, {7'h00, en_out});
    chk("irq_on", 8'h00, {7'h00, irq});
    rd(OFS_RAIL_CTRL, 8'h01);
    rd(OFS_RAIL_STATUS, 8'h06);
    wr(OFS_RAIL_STATUS, 8'h01);
    @(negedge clk);
    chk("irq_clr", 8'h00, {7'h00, irq});
    fail = 1'b1;
    repeat (6) @(negedge clk);
    chk("irq_set", 8'h01, {7'h00, irq});
    // A clear while the rail is still down must lose to the fault
    wr(OFS_RAIL_STATUS, 8'h01);
    @(negedge clk);
    chk("irq_hold", 8'h01, {7'h00, irq});
    rd(OFS_RAIL_STATUS, 8'h03);
    fail = 1'b0;
    repeat (4) @(negedge clk);
    wr(OFS_RAIL_STATUS, 8'h01);
    trip_n = 1'b0;
    repeat (5) @(negedge clk);
    chk("trip_en", 8'h00, {7'h00, en_out});
    trip_n = 1'b1;
    repeat (5) @(negedge clk);
    chk("rail_back", 8'h01, {7'h00, en_out});
    chk("irq_back", 8'h00, {7'h00, irq});
    wr(OFS_RAIL_CTRL, 8'h00);
    repeat (3) @(negedge clk);
    chk("rail_off", 8'h00, {7'h00, en_out});
    summarize();
  end
endmodule
